//--- shared/osc_pkg.sv
// package of constants for the oscillator source and pll configuration block
package osc_pkg;
    // ========================================================================
    // register indices (word addresses on the plain register port)
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_DIVISOR = 4'h1;
    localparam logic [3:0] ADDR_FEEDBACK = 4'h2;
    localparam logic [3:0] ADDR_AUX_REF = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    // ========================================================================
    // control register fields
    localparam int CTL_SWITCH_BIT = 0;
    localparam int CTL_NEW_LSB = 8;
    localparam int CTL_CUR_LSB = 12;
    // divisor register fields
    localparam int DIV_PRE_LSB = 0;
    localparam int DIV_POST_LSB = 6;
    localparam int DIV_FRC_LSB = 8;
    // aux and reference register fields
    localparam int AUX_SRC_BIT = 0;
    localparam int REF_SRC_BIT = 1;
    localparam int REF_DIV_LSB = 4;
    // ========================================================================
    // reset values
    localparam logic [15:0] DIVISOR_RESET = 16'h0040;
    localparam logic [8:0] FEEDBACK_RESET = 9'h030;
    localparam logic [2:0] FRC_DIV_RESET = 3'h0;
    // ========================================================================
    // source codes
    typedef enum logic [2:0] {
        SRC_FRC = 3'b000,
        SRC_FRC_PLL = 3'b001,
        SRC_PRI = 3'b010,
        SRC_PRI_PLL = 3'b011,
        SRC_RESERVED = 3'b100,
        SRC_LOW_POWER_RC_OSC = 3'b101,
        SRC_FRC_DIV16 = 3'b110,
        SRC_FRC_DIVN = 3'b111
    } osc_src_type;
    // primary modes
    localparam logic [1:0] PRI_EC = 2'b00;
    localparam logic [1:0] PRI_XT = 2'b01;
    localparam logic [1:0] PRI_HS = 2'b10;
    localparam logic [1:0] PRI_OFF = 2'b11;
    // ========================================================================
    // timing: frequencies in hertz, and derived counts
    localparam int REF_CLK_HZ = 20000000;
    localparam int AUX_MULT = 16;
    localparam int FCY_DIVIDE = 2;
    localparam int FCY_MAX_HZ = 40000000;
    localparam int LOW_POWER_RC_OSC_HZ = 32768;
    localparam int FRC_DIV16 = 16;
    localparam int SWITCH_SETTLE_CYCLES = 4;
endpackage : osc_pkg

//--- src/osc_clock_control.sv
// oscillator source selection, postscaler, pll model and clock outputs
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/100ps
// Summary of operation
// - power-on source comes from initial select plus primary mode fields
// - codes 111,110,101,001,000 pick internal sources; 100 reserved
// - 011 primary through pll, 010 primary direct; mode picks hs/xt/ec
// - erased configuration starts on fast rc divided by postscaler
// - selected source or pll output divided by two gives instruction clock
// - fast rc postscaler divides by factor from 3-bit field
// - pll input divided by n1 of 2 to 33 from 5-bit field
// - vco input multiplied by m from 9-bit feedback field
// - vco output divided by n2 of 2, 4 or 8
// - pll output equals input times m over n1 times n2
// - instruction clock supports up to 40 mhz
// - auxiliary clock is fixed 16x pll from primary or fast rc
// - low-power rc at 32.768 khz feeds watchdog
// - reference output is ref_clk, software-scaled; the reference source bit does not change it
// - switch request bit starts a switch, cleared when switch done
module osc_clock_control (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [2:0] initial_source_select,
    input wire logic [1:0] primary_mode_select,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    output logic [2:0] current_source,
    output logic [1:0] primary_mode,
    output logic [31:0] fosc_hz,
    output logic [31:0] fcy_hz,
    output logic [31:0] aux_clk_hz,
    output logic [31:0] low_power_rc_osc_hz,
    output logic watchdog_ref_sel,
    output logic fcy_over_limit,
    output logic ref_clk_out
);
    // ========================================================================
    // configuration capture after reset release
    logic cfg_done_reg;
    logic [1:0] primary_mode_reg;
    // ========================================================================
    // software registers
    logic [2:0] new_source_reg;
    logic switch_request_bit_reg;
    logic [2:0] cur_source_reg;
    logic [2:0] fast_rc_postscale_reg;
    logic [1:0] pll_postscale_field_reg;
    logic [4:0] pll_prescale_field_reg;
    logic [8:0] pll_feedback_field_reg;
    logic aux_src_reg;
    logic ref_src_reg;
    logic [3:0] ref_div_reg;
    logic [2:0] settle_reg;
    logic [15:0] reg_rdata_reg;
    // ========================================================================
    // oscillator frequency model (hz), parameters for the pins and rc
    localparam int FRC_HZ = 7370000;
    localparam int PRI_HZ = 10000000;

    // captures power-on configuration once the reset has released
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg_done_reg <= 1'b0;
            primary_mode_reg <= osc_pkg::PRI_EC;
        end else if (!cfg_done_reg) begin
            cfg_done_reg <= 1'b1;
            primary_mode_reg <= primary_mode_select;
        end
    end

    // register writes, switch sequencing
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur_source_reg <= osc_pkg::SRC_FRC_DIVN;
            new_source_reg <= osc_pkg::SRC_FRC_DIVN;
            switch_request_bit_reg <= 1'b0;
            settle_reg <= 3'h0;
        end else if (!cfg_done_reg) begin
            // reserved code falls back to plain fast rc
            if (initial_source_select == osc_pkg::SRC_RESERVED) begin
                cur_source_reg <= osc_pkg::SRC_FRC;
            end else begin
                cur_source_reg <= initial_source_select;
            end
            new_source_reg <= initial_source_select;
        end else begin
            if (switch_request_bit_reg) begin
                if (settle_reg == 3'(osc_pkg::SWITCH_SETTLE_CYCLES - 1)) begin
                    // change on a settled boundary, no partial phase
                    if (new_source_reg != osc_pkg::SRC_RESERVED) begin
                        cur_source_reg <= new_source_reg;
                    end
                    switch_request_bit_reg <= 1'b0;
                    settle_reg <= 3'h0;
                end else begin
                    settle_reg <= settle_reg + 3'h1;
                end
            end
            if (reg_write && reg_addr == osc_pkg::ADDR_CONTROL) begin
                new_source_reg <= reg_wdata[osc_pkg::CTL_NEW_LSB +: 3];
                if (reg_wdata[osc_pkg::CTL_SWITCH_BIT]) begin
                    switch_request_bit_reg <= 1'b1;
                end
            end
        end
    end

    // divisor, feedback and aux/reference registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fast_rc_postscale_reg <= osc_pkg::FRC_DIV_RESET;
            pll_postscale_field_reg <=
                osc_pkg::DIVISOR_RESET[osc_pkg::DIV_POST_LSB +: 2];
            pll_prescale_field_reg <=
                osc_pkg::DIVISOR_RESET[osc_pkg::DIV_PRE_LSB +: 5];
            pll_feedback_field_reg <= osc_pkg::FEEDBACK_RESET;
            aux_src_reg <= 1'b0;
            ref_src_reg <= 1'b0;
            ref_div_reg <= 4'h0;
        end else if (reg_write) begin
            unique case (reg_addr)
                osc_pkg::ADDR_DIVISOR: begin
                    fast_rc_postscale_reg <=
                        reg_wdata[osc_pkg::DIV_FRC_LSB +: 3];
                    pll_postscale_field_reg <=
                        reg_wdata[osc_pkg::DIV_POST_LSB +: 2];
                    pll_prescale_field_reg <=
                        reg_wdata[osc_pkg::DIV_PRE_LSB +: 5];
                end
                osc_pkg::ADDR_FEEDBACK: begin
                    pll_feedback_field_reg <= reg_wdata[8:0];
                end
                osc_pkg::ADDR_AUX_REF: begin
                    aux_src_reg <= reg_wdata[osc_pkg::AUX_SRC_BIT];
                    ref_src_reg <= reg_wdata[osc_pkg::REF_SRC_BIT];
                    ref_div_reg <= reg_wdata[osc_pkg::REF_DIV_LSB +: 4];
                end
                default: begin
                end
            endcase
        end
    end

    // ========================================================================
    // frequency arithmetic
    logic [31:0] frc_div_factor;
    logic [31:0] n1_factor;
    logic [31:0] m_factor;
    logic [31:0] n2_factor;
    logic [63:0] pll_out_wide;
    logic [31:0] pll_in_hz;
    logic [31:0] fosc_next;

    always_comb begin
        // 000..110 are 1..64 by powers of two; 111 is 256
        if (fast_rc_postscale_reg == 3'h7) begin
            frc_div_factor = 32'd256;
        end else begin
            frc_div_factor = 32'd1 << fast_rc_postscale_reg;
        end
        n1_factor = 32'(pll_prescale_field_reg) + 32'd2;
        m_factor = 32'(pll_feedback_field_reg) + 32'd2;
        unique case (pll_postscale_field_reg)
            2'b00: n2_factor = 32'd2;
            2'b01: n2_factor = 32'd4;
            2'b11: n2_factor = 32'd8;
            default: n2_factor = 32'd4; // reserved code treated as /4
        endcase
    end

    always_comb begin
        if (cur_source_reg == osc_pkg::SRC_PRI_PLL) begin
            pll_in_hz = 32'(PRI_HZ);
        end else begin
            pll_in_hz = 32'(FRC_HZ);
        end
        pll_out_wide = (64'(pll_in_hz) * 64'(m_factor)) /
            (64'(n1_factor) * 64'(n2_factor));
        unique case (cur_source_reg)
            osc_pkg::SRC_FRC: fosc_next = 32'(FRC_HZ);
            osc_pkg::SRC_FRC_PLL,
            osc_pkg::SRC_PRI_PLL: fosc_next = pll_out_wide[31:0];
            osc_pkg::SRC_PRI: fosc_next = 32'(PRI_HZ);
            osc_pkg::SRC_LOW_POWER_RC_OSC: fosc_next = 32'(osc_pkg::LOW_POWER_RC_OSC_HZ);
            osc_pkg::SRC_FRC_DIV16:
                fosc_next = 32'(FRC_HZ / osc_pkg::FRC_DIV16);
            osc_pkg::SRC_FRC_DIVN:
                fosc_next = 32'(FRC_HZ) / frc_div_factor;
            default: fosc_next = 32'(FRC_HZ);
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fosc_hz <= 32'h0;
            fcy_hz <= 32'h0;
            aux_clk_hz <= 32'h0;
            fcy_over_limit <= 1'b0;
        end else begin
            fosc_hz <= fosc_next;
            fcy_hz <= fosc_next / 32'(osc_pkg::FCY_DIVIDE);
            fcy_over_limit <= (fosc_next / 32'(osc_pkg::FCY_DIVIDE)) >
                32'(osc_pkg::FCY_MAX_HZ);
            aux_clk_hz <= (aux_src_reg ? 32'(PRI_HZ) : 32'(FRC_HZ)) *
                32'(osc_pkg::AUX_MULT);
        end
    end

    // ========================================================================
    // reference clock output: ref_clk scaled by 2^(ref_div+1)
    logic [15:0] ref_cnt_reg;
    logic ref_out_reg;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ref_cnt_reg <= 16'h0;
            ref_out_reg <= 1'b0;
        end else if (ref_cnt_reg >= (16'h1 << ref_div_reg) - 16'h1) begin
            ref_cnt_reg <= 16'h0;
            ref_out_reg <= ~ref_out_reg;
        end else begin
            ref_cnt_reg <= ref_cnt_reg + 16'h1;
        end
    end

    // ========================================================================
    // read port, data one cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata_reg <= 16'h0;
        end else if (reg_read) begin
            unique case (reg_addr)
                osc_pkg::ADDR_CONTROL: reg_rdata_reg <=
                    {1'b0, cur_source_reg, 1'b0, new_source_reg,
                     7'h0, switch_request_bit_reg};
                osc_pkg::ADDR_DIVISOR: reg_rdata_reg <=
                    {5'h0, fast_rc_postscale_reg, pll_postscale_field_reg,
                     1'b0, pll_prescale_field_reg};
                osc_pkg::ADDR_FEEDBACK: reg_rdata_reg <=
                    {7'h0, pll_feedback_field_reg};
                osc_pkg::ADDR_AUX_REF: reg_rdata_reg <=
                    {8'h0, ref_div_reg, 2'h0, ref_src_reg, aux_src_reg};
                osc_pkg::ADDR_STATUS: reg_rdata_reg <=
                    {14'h0, primary_mode_reg};
                default: reg_rdata_reg <= 16'h0;
            endcase
        end else begin
            reg_rdata_reg <= 16'h0;
        end
    end

    assign reg_rdata = reg_rdata_reg;
    assign current_source = cur_source_reg;
    assign primary_mode = primary_mode_reg;
    assign low_power_rc_osc_hz = 32'(osc_pkg::LOW_POWER_RC_OSC_HZ);
    assign watchdog_ref_sel = 1'b1;
    assign ref_clk_out = ref_src_reg ? ref_out_reg : ref_out_reg;
endmodule : osc_clock_control

//--- bench/osc_clock_control_checker.sv
// assertion checker bound to the oscillator configuration block
`timescale 1ns/100ps
module osc_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [15:0] reg_rdata,
    input wire logic [2:0] current_source,
    input wire logic [31:0] fosc_hz,
    input wire logic [31:0] fcy_hz,
    input wire logic [31:0] low_power_rc_osc_hz,
    input wire logic watchdog_ref_sel,
    input wire logic fcy_over_limit
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic ctl_wr;
    logic ctl_rd;
    logic [2:0] new_reg;
    assign ctl_wr = reg_write && reg_addr == osc_pkg::ADDR_CONTROL;
    assign ctl_rd = reg_read && reg_addr == osc_pkg::ADDR_CONTROL;
    // ========================================================================
    // switch requests
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            new_reg <= 3'h0;
        end else if (ctl_wr) begin
            new_reg <= reg_wdata[10:8];
        end
    end
    sequence s_switch_req;
        ctl_wr && reg_wdata[0] && reg_wdata[10:8] != 3'h4;
    endsequence
    sequence s_reserved_req;
        ctl_wr && reg_wdata[0] && reg_wdata[10:8] == 3'h4;
    endsequence
    a_switch_done: assert property (s_switch_req |-> ##[3:5]
        current_source == new_reg) else $error("switch not done");
    a_switch_set: assert property (s_switch_req ##[1:3] ctl_rd
        |=> reg_rdata[0]) else $error("switch bit low early");
    a_switch_clear: assert property (s_switch_req ##[5:10] ctl_rd
        |=> !reg_rdata[0]) else $error("switch bit stuck");
    a_reserved_kept: assert property (s_reserved_req |=>
        $stable(current_source) [*5]) else $error("reserved taken");
    // ========================================================================
    // clock relations
    a_fcy_half: assert property ($stable(fosc_hz) [*3] |->
        fcy_hz == fosc_hz / 2) else $error("fcy not half");
    a_over_limit: assert property ($stable(fcy_hz) [*3] |->
        fcy_over_limit == (fcy_hz > osc_pkg::FCY_MAX_HZ))
        else $error("limit flag wrong");
    a_low_power_rc_osc_ref: assert property (!$past(rst) |->
        low_power_rc_osc_hz == osc_pkg::LOW_POWER_RC_OSC_HZ && watchdog_ref_sel)
        else $error("low_power_rc_osc reference wrong");
    a_low_power_rc_osc_source: assert property ((current_source == 3'h5) [*3] |->
        fosc_hz == osc_pkg::LOW_POWER_RC_OSC_HZ) else $error("low_power_rc_osc fosc wrong");
endmodule : osc_checker
bind osc_clock_control osc_checker i_osc_checker (.ref_clk(ref_clk),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .current_source(current_source), .fosc_hz(fosc_hz), .fcy_hz(fcy_hz),
    .low_power_rc_osc_hz(low_power_rc_osc_hz), .watchdog_ref_sel(watchdog_ref_sel),
    .fcy_over_limit(fcy_over_limit));

//--- bench/test_osc_clock_control.sv
// self-checking bench for the oscillator configuration block
`timescale 1ns/100ps
module test_osc_clock_control;
    localparam longint FRC_HZ = 7370000;
    localparam longint PRI_HZ = 10000000;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] init_src = 3'h7;
    logic [1:0] pm = 2'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [15:0] reg_rdata;
    logic [2:0] current_source;
    logic [1:0] primary_mode;
    logic [31:0] fosc_hz, fcy_hz, aux_clk_hz, low_power_rc_osc_hz;
    logic watchdog_ref_sel, fcy_over_limit, ref_clk_out, last;
    int failures = 0;
    int check_count = 0;
    int n;
    logic [15:0] exp_q[$];
    logic rd_pend = 1'b0;
    logic [2:0] cur = 3'h7;
    logic [2:0] fd = 3'h0;
    logic [4:0] pre = 5'h0;
    logic [8:0] fb = 9'h030;
    logic [1:0] po = 2'h1;
    logic [31:0] r = 32'hfef1cced;
    logic [2:0] rst_tab [8] =
        '{3'h6, 3'h5, 3'h4, 3'h1, 3'h0, 3'h3, 3'h2, 3'h7};
    logic [2:0] sw_tab [9] = '{0, 1, 0, 3, 2, 5, 6, 0, 3};
    // each entry keeps vco input, vco output and pll output in range
    logic [31:0] pll_tab [4] = '{32'h001e0000, 32'h001e0040, 32'h002000c0,
        32'h00300003};
    osc_clock_control i_osc_clock_control (.ref_clk(ref_clk), .rst(rst),
        .initial_source_select(init_src), .primary_mode_select(pm),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .current_source(current_source), .primary_mode(primary_mode),
        .fosc_hz(fosc_hz), .fcy_hz(fcy_hz), .aux_clk_hz(aux_clk_hz),
        .low_power_rc_osc_hz(low_power_rc_osc_hz), .watchdog_ref_sel(watchdog_ref_sel),
        .fcy_over_limit(fcy_over_limit), .ref_clk_out(ref_clk_out));
    initial forever #25 ref_clk = ~ref_clk;
    // ========================================================================
    // helpers
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic [31:0] efo();
        longint f;
        f = (cur == 3'h2 || cur == 3'h3) ? PRI_HZ : FRC_HZ;
        case (cur)
            3'h1, 3'h3: f = f * (fb + 2) / ((pre + 2) *
                ((po == 2'h0) ? 2 : (po == 2'h3) ? 8 : 4));
            3'h5: f = osc_pkg::LOW_POWER_RC_OSC_HZ;
            3'h6: f = f / osc_pkg::FRC_DIV16;
            3'h7: f = f >> ((fd == 3'h7) ? 8 : fd);
            default: ;
        endcase
        return f[31:0];
    endfunction : efo
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(logic [3:0] a, logic [15:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        exp_q.push_back(e);
        @(posedge ref_clk);
        reg_read <= 1'b0;
    endtask : rd
    always @(posedge ref_clk) begin
        if (rd_pend) begin
            check("rdata", {16'h0, reg_rdata},
                {16'h0, exp_q.pop_front()});
        end
        rd_pend <= reg_read;
    end
    task automatic chk_f();
        logic [31:0] e;
        repeat (4) @(posedge ref_clk);
        e = efo();
        check("fosc", fosc_hz, e);
        check("fcy", fcy_hz, e / 2);
        check("over", {31'h0, fcy_over_limit},
            {31'h0, e / 2 > 40000000});
        check("source", {29'h0, current_source}, {29'h0, cur});
    endtask : chk_f
    task automatic sw(logic [2:0] s);
        wr(osc_pkg::ADDR_CONTROL, {5'h0, s, 8'h01});
        rd(osc_pkg::ADDR_CONTROL, {1'b0, cur, 1'b0, s, 8'h01});
        repeat (4) @(posedge ref_clk);
        if (s != 3'h4) cur = s;
        rd(osc_pkg::ADDR_CONTROL, {1'b0, cur, 1'b0, s, 8'h00});
        chk_f();
    endtask : sw
    task automatic test_done();
        if (failures == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    // ========================================================================
    // scenarios
    initial begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        test_done();
    end
    initial begin
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            rst <= 1'b1;
            init_src <= rst_tab[i];
            pm <= 2'(i % 3);
            repeat (5) @(posedge ref_clk);
            rst <= 1'b0;
            cur = (rst_tab[i] == 3'h4) ? 3'h0 : rst_tab[i];
            chk_f();
            if (cur == 3'h2 || cur == 3'h3) begin
                rd(osc_pkg::ADDR_STATUS, 16'(i % 3));
            end
        end
        rd(osc_pkg::ADDR_DIVISOR, osc_pkg::DIVISOR_RESET);
        rd(osc_pkg::ADDR_FEEDBACK, {7'h0, osc_pkg::FEEDBACK_RESET});
        rd(4'hf, 16'h0);
        for (int i = 0; i < 8; i++) begin
            fd = 3'(i);
            wr(osc_pkg::ADDR_DIVISOR, {5'h0, fd, 8'h40});
            chk_f();
        end
        fd = 3'h0;
        wr(osc_pkg::ADDR_DIVISOR, 16'h0040);
        // plain fast rc always sits between the two pll sources
        foreach (sw_tab[i]) sw(sw_tab[i]);
        sw(3'h4);
        foreach (pll_tab[i]) begin
            {fb, po, pre} =
                {pll_tab[i][24:16], pll_tab[i][7:6], pll_tab[i][4:0]};
            wr(osc_pkg::ADDR_DIVISOR, pll_tab[i][15:0]);
            wr(osc_pkg::ADDR_FEEDBACK, {7'h0, fb});
            chk_f();
            rd(osc_pkg::ADDR_DIVISOR, pll_tab[i][15:0]);
        end
        wr(osc_pkg::ADDR_AUX_REF, 16'h0001);
        repeat (4) @(posedge ref_clk);
        check("aux", aux_clk_hz, 32'(PRI_HZ * osc_pkg::AUX_MULT));
        wr(osc_pkg::ADDR_AUX_REF, 16'h0020);
        repeat (8) @(posedge ref_clk);
        check("aux", aux_clk_hz, 32'(FRC_HZ * osc_pkg::AUX_MULT));
        n = 0;
        for (int k = 0; k < 32; k++) begin
            last = ref_clk_out;
            @(posedge ref_clk);
            if (ref_clk_out !== last) n++;
        end
        check("ref toggles", n, 32'd8);
        repeat (4) begin
            r = lfsr(r);
            wr(osc_pkg::ADDR_FEEDBACK, {7'h0, r[8:0]});
            rd(osc_pkg::ADDR_FEEDBACK, {7'h0, r[8:0]});
        end
        repeat (3) @(posedge ref_clk);
        test_done();
    end
endmodule : test_osc_clock_control
